// >>> verif/sgpio_pad_model.sv
// Purpose: pad and outside-world model for the shared port
// Assumes: outside drivers back off wherever the port or a peripheral drives
// Notes: an undriven, unpulled pad flips every cycle, never a stale level

`timescale 1ns/100ps

module sgpio_pad_model (
  // clock
  input wire logic mclk,
  // from the port
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  // outside drivers and pull-ups
  input wire logic [15:0] ext_en,
  input wire logic [15:0] ext_val,
  // to the port
  output logic [15:0] pin_in
);
  logic [15:0] float_q = 16'h0000;

  always_ff @(posedge mclk) begin
    float_q <= ~float_q;
  end

  // released open-drain pins fall back to the outside level
  always_comb begin
    pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
      | (pin_oe_n & ~ext_en & float_q);
  end
endmodule

// >>> verif/tb.sv
// Purpose: self-checking bench of the shared port
// Assumes: stimulus on rising edges, checks on falling edges
// Notes: fixed seed; corner cases mixed into the random loop

`timescale 1ns/100ps

module tb;
  // ----------------------------------------
  // signals and models
  // ----------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] wdata = 16'h0000;
  logic [9:0] wr = 10'h000;
  logic [1:0] adc_dis = 2'h0;
  logic [15:0] pe = 16'h0000, pd = 16'h0000, po = 16'h0000, ext_val = 16'h0000;
  logic [23:0] change_pin = 24'h000000;
  logic change_flag_clr = 1'b0;
  logic [15:0] dir_r, lat_r, pv_r, odc_r, c1_r, c2_r, ena_r, pua_r;
  logic [7:0] enb_r, pub_r;
  logic [15:0] periph_in, pin_analog, pin_in, pin_out, pin_oe_n;
  logic [23:0] change_pullup_en, en_m, pu_m, e;
  logic change_flag, change_wake;
  logic [15:0] dir_m, lat_m, odc_m, c1_m, c2_m;
  int seed = 32'h1c60db79;
  int mismatches = 0;
  int check_count = 0;
  int k;

  always #50 mclk = ~mclk;

  sgpio_port uut (.mclk(mclk), .rst(rst), .wdata(wdata), .wr_direction(wr[0]),
    .wr_latch(wr[1]), .wr_pin_value(wr[2]), .wr_open_drain(wr[3]),
    .wr_analog_cfg_1(wr[4]), .wr_analog_cfg_2(wr[5]), .wr_change_en_a(wr[6]),
    .wr_change_en_b(wr[7]), .wr_pullup_a(wr[8]), .wr_pullup_b(wr[9]),
    .pin_direction_reg(dir_r), .output_latch_reg(lat_r), .pin_value_reg(pv_r),
    .open_drain_select_reg(odc_r), .analog_cfg_1(c1_r), .analog_cfg_2(c2_r),
    .change_irq_enable_reg_a(ena_r), .change_irq_enable_reg_b(enb_r),
    .weak_pullup_enable_reg_a(pua_r), .weak_pullup_enable_reg_b(pub_r),
    .adc1_disable(adc_dis[0]), .adc2_disable(adc_dis[1]), .periph_enable(pe),
    .periph_drive(pd), .periph_out(po), .periph_in(periph_in),
    .pin_analog(pin_analog), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .change_pin(change_pin), .change_pullup_en(change_pullup_en),
    .change_flag_clr(change_flag_clr), .change_flag(change_flag),
    .change_wake(change_wake));

  sgpio_pad_model pads (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_en(16'hffff), .ext_val(ext_val), .pin_in(pin_in));

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    return 16'($random(seed));
  endfunction

  function automatic logic [15:0] own();
    return pe & pd & ~sgpio_pkg::INPUT_ONLY_MASK & sgpio_pkg::IMPL_MASK;
  endfunction

  function automatic logic [15:0] exp_oe_n();
    return ~(own() | (~dir_m & ~(odc_m & lat_m) & sgpio_pkg::IMPL_MASK));
  endfunction

  function automatic logic [15:0] exp_out();
    return (own() & po) | (~own() & lat_m);
  endfunction

  function automatic logic [15:0] exp_analog();
    return ((~c1_m & {16{~adc_dis[0]}}) | (~c2_m & {16{~adc_dis[1]}}))
      & sgpio_pkg::ANALOG_MASK;
  endfunction

  // ----------------------------------------
  // compares and closing
  // ----------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk24(input logic [23:0] got, input logic [23:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // stimulus tasks
  // ----------------------------------------
  task automatic wreg(input int r, input logic [15:0] v);
    @(posedge mclk);
    wdata <= v;
    wr <= 10'h001 << r;
    @(posedge mclk);
    wr <= 10'h000;
    case (r)
      0: dir_m = v & sgpio_pkg::IMPL_MASK;
      1, 2: lat_m = v & sgpio_pkg::IMPL_MASK;
      3: odc_m = v & sgpio_pkg::IMPL_MASK;
      4: c1_m = v | ~sgpio_pkg::ANALOG_MASK;
      5: c2_m = v | ~sgpio_pkg::ANALOG_MASK;
      6: en_m[15:0] = v;
      7: en_m[23:16] = v[7:0];
      8: pu_m[15:0] = v;
      default: pu_m[23:16] = v[7:0];
    endcase
  endtask

  task automatic check_all();
    logic [15:0] oe;
    logic [15:0] an;
    oe = exp_oe_n();
    an = exp_analog();
    chk16(dir_r, dir_m, "direction");
    chk16(lat_r, lat_m, "latch");
    chk16(odc_r, odc_m, "open drain reg");
    chk16(c1_r, c1_m, "cfg one");
    chk16(c2_r, c2_m, "cfg two");
    chk24({enb_r, ena_r}, en_m, "change enable");
    chk24({pub_r, pua_r}, pu_m, "pullup reg");
    chk24(change_pullup_en, pu_m, "pullup out");
    chk16(pin_analog, an, "analog");
    chk16(pin_oe_n, oe, "drive enable");
    chk16(pin_out & ~pin_oe_n, exp_out() & ~oe, "pad data");
    chk16(pv_r, ((~oe & exp_out()) | (oe & ext_val)) & ~an & sgpio_pkg::IMPL_MASK, "pins");
    chk16(periph_in & ~oe & ~own(), 16'h0000, "loop through");
    chk16(periph_in & own() & ~an, po & own() & ~an, "periph in");
  endtask

  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    pe <= 16'h0000;
    ext_val <= 16'h0000;
    dir_m = sgpio_pkg::IMPL_MASK;
    lat_m = 16'h0000;
    odc_m = 16'h0000;
    c1_m = ~sgpio_pkg::ANALOG_MASK;
    c2_m = ~sgpio_pkg::ANALOG_MASK;
    en_m = 24'h000000;
    pu_m = 24'h000000;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check_all();
    chk24({22'h0, change_wake, change_flag}, 24'h000000, "reset flag");
    @(posedge mclk);
    rst <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    for (int n = 0; n < 40; n++) begin
      @(posedge mclk);
      adc_dis <= 2'(n >> 2);
      pe <= rnd();
      pd <= rnd();
      po <= rnd();
      ext_val <= (n == 1) ? 16'hffff : rnd();
      wreg(4, rnd());
      wreg(5, rnd());
      wreg(3, (n == 1) ? 16'hffff : rnd());
      wreg(n[0] ? 2 : 1, rnd());
      wreg(0, ((n == 0) ? 16'h0000 : rnd()) | exp_analog());
      wreg(6, rnd());
      wreg(9, rnd());
      wreg(8, rnd() & dir_m);
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      check_all();
    end
    do_reset();
    for (int i = 0; i < 24; i++) begin
      e = 24'h000001 << i;
      wreg(6, e[15:0]);
      wreg(7, {8'h00, e[23:16]});
      change_pin <= change_pin ^ {e[22:0], e[23]};
      @(negedge mclk);
      chk24({22'h0, change_wake, change_flag}, 24'h000000, "disabled wake");
      repeat (6) @(negedge mclk);
      chk24({22'h0, change_wake, change_flag}, 24'h000000, "disabled flag");
      @(posedge mclk);
      change_pin <= change_pin ^ e;
      @(negedge mclk);
      chk24({22'h0, change_wake, change_flag}, 24'h000002, "wake");
      k = 0;
      while (change_flag !== 1'b1 && k < 6) begin
        @(negedge mclk);
        k++;
      end
      chk24({23'h0, change_flag}, 24'h000001, "change flag");
      if (change_flag !== 1'b1) begin
        tally_and_finish();
      end
      repeat (2) @(negedge mclk);
      chk24({23'h0, change_flag}, 24'h000001, "sticky flag");
      @(posedge mclk);
      change_flag_clr <= 1'b1;
      @(posedge mclk);
      change_flag_clr <= 1'b0;
      @(negedge mclk);
      chk24({22'h0, change_wake, change_flag}, 24'h000000, "cleared");
    end
    // corner: clear lands in the very cycle the flag sets
    @(posedge mclk);
    change_pin <= change_pin ^ 24'h800000;
    repeat (2) @(posedge mclk);
    change_flag_clr <= 1'b1;
    @(posedge mclk);
    change_flag_clr <= 1'b0;
    @(negedge mclk);
    chk24({23'h0, change_flag}, 24'h000001, "set beats clear");
    @(posedge mclk);
    change_flag_clr <= 1'b1;
    @(posedge mclk);
    change_flag_clr <= 1'b0;
    @(negedge mclk);
    chk24({22'h0, change_wake, change_flag}, 24'h000000, "cleared after win");
    tally_and_finish();
  end
endmodule

// >>> verilog/sgpio_cn.sv
// Purpose: change-notify detector with one sticky shared flag
// Assumes: raw inputs asynchronous, synchronous active-high reset
// Notes: wake needs no clock, the sticky flag does

`timescale 1ns/100ps

module sgpio_cn (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link to port block
  sgpio_cn_if.cn cn
);

  sgpio_pkg::sgpio_cn_st_t st_q;
  sgpio_pkg::sgpio_cn_st_t st_d;
  logic [23:0] change;

  // detection compares against the last recorded level
  assign change = (st_q.cn_s2 ^ st_q.cn_prev) & cn.en & {24{st_q.vld[2]}};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.cn_s1 = cn.raw;
    st_d.cn_s2 = st_q.cn_s1;
    st_d.cn_prev = st_q.cn_s2;
    // ignore the first cycles until prev holds a real sample
    st_d.vld = {st_q.vld[1:0], 1'b1};
    // a change in the clear cycle keeps the flag set
    st_d.flag = (st_q.flag & ~cn.clr) | (|change);
    if (rst) begin
      st_d.cn_s1 = '0;
      st_d.cn_s2 = '0;
      st_d.cn_prev = '0;
      st_d.vld = sgpio_pkg::VLD_RST;
      st_d.flag = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  assign cn.flag = st_q.flag;
  // clockless path for sleep: raw pin against held level
  assign cn.wake = |((cn.raw ^ st_q.cn_prev) & cn.en & {24{st_q.vld[2]}});

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_flag_sets_on_change: assert property (@(posedge mclk) disable iff (rst)
    |change |=> st_q.flag)
    else $error("change did not set flag");
  a_flag_holds_sticky: assert property (@(posedge mclk) disable iff (rst)
    st_q.flag && !cn.clr |=> st_q.flag)
    else $error("flag dropped without clear");
  a_disabled_no_flag: assert property (@(posedge mclk) disable iff (rst)
    !st_q.flag && cn.en == '0 |=> !st_q.flag)
    else $error("flag set with no enable");
  c_change_seen: cover property (@(posedge mclk) disable iff (rst)
    !st_q.flag ##1 st_q.flag);
  c_set_during_clr: cover property (@(posedge mclk) disable iff (rst)
    cn.clr && |change);

endmodule

// >>> verilog/sgpio_cn_if.sv
// Purpose: carries change-notify signals between the port block and its detector
// Assumes: raw pins are asynchronous to mclk
// Notes: wake is combinational from the raw pins on purpose

`timescale 1ns/100ps

interface sgpio_cn_if;
  logic [23:0] raw;
  logic [23:0] en;
  logic clr;
  logic flag;
  logic wake;

  modport port (
    output raw,
    output en,
    output clr,
    input flag,
    input wake
  );

  modport cn (
    input raw,
    input en,
    input clr,
    output flag,
    output wake
  );
endinterface

// >>> verilog/sgpio_pkg.sv
// Purpose: shared constants and types of the shared gpio port with change notify
// Assumes: one 16-bit port with 15 pins, 24 change-notify inputs, two converter modules
// Notes: masks describe which pins exist, have an analog function or are input-only

package sgpio_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int PORT_W = 16;
  localparam int CN_W = 24;
  localparam int CN_A_W = 16;
  localparam int CN_B_W = 8;
  localparam int CN_B_LSB = 16;
  localparam int SYNC_VLD_W = 3;

  // ----------------------------------------
  // pin population of this variant
  // ----------------------------------------
  localparam logic [15:0] IMPL_MASK = 16'h7fff;
  localparam logic [15:0] ANALOG_MASK = 16'h00ff;
  localparam logic [15:0] INPUT_ONLY_MASK = 16'h1000;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] DIR_RST = 16'hffff;
  localparam logic [15:0] LAT_RST = 16'h0000;
  localparam logic [15:0] ODC_RST = 16'h0000;
  localparam logic [15:0] ANALOG_SELECT_BIT_RST = 16'h0000;
  localparam logic [23:0] CN_EN_RST = 24'h000000;
  localparam logic [23:0] CN_PU_RST = 24'h000000;
  localparam logic [2:0] VLD_RST = 3'h0;

  // ----------------------------------------
  // state of the port block
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] pin_direction_reg;
    logic [15:0] output_latch_reg;
    logic [15:0] open_drain_select_reg;
    logic [15:0] analog_cfg_1;
    logic [15:0] analog_cfg_2;
    logic [23:0] change_irq_enable;
    logic [23:0] weak_pullup_enable;
    logic [15:0] pin_s1;
    logic [15:0] pin_s2;
    logic [15:0] pin_value_reg;
  } sgpio_port_st_t;

  // ----------------------------------------
  // state of the change-notify unit
  // ----------------------------------------
  typedef struct packed {
    logic [23:0] cn_s1;
    logic [23:0] cn_s2;
    logic [23:0] cn_prev;
    logic [2:0] vld;
    logic flag;
  } sgpio_cn_st_t;

endpackage

// >>> verilog/sgpio_port.sv
// Purpose: one shared parallel port: direction, latch, readback, pin arbitration,
//   open-drain, analog config and change notification
// Assumes: pins asynchronous to mclk; peripherals on mclk
// Notes: register contents are plain ports, written by one-cycle strobes

`timescale 1ns/100ps

module sgpio_port (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register writes
  input wire logic [15:0] wdata,
  input wire logic wr_direction,
  input wire logic wr_latch,
  input wire logic wr_pin_value,
  input wire logic wr_open_drain,
  input wire logic wr_analog_cfg_1,
  input wire logic wr_analog_cfg_2,
  input wire logic wr_change_en_a,
  input wire logic wr_change_en_b,
  input wire logic wr_pullup_a,
  input wire logic wr_pullup_b,
  // register readback
  output logic [15:0] pin_direction_reg,
  output logic [15:0] output_latch_reg,
  output logic [15:0] pin_value_reg,
  output logic [15:0] open_drain_select_reg,
  output logic [15:0] analog_cfg_1,
  output logic [15:0] analog_cfg_2,
  output logic [15:0] change_irq_enable_reg_a,
  output logic [7:0] change_irq_enable_reg_b,
  output logic [15:0] weak_pullup_enable_reg_a,
  output logic [7:0] weak_pullup_enable_reg_b,
  // converter module disables
  input wire logic adc1_disable,
  input wire logic adc2_disable,
  // sharing peripherals
  input wire logic [15:0] periph_enable,
  input wire logic [15:0] periph_drive,
  input wire logic [15:0] periph_out,
  output logic [15:0] periph_in,
  output logic [15:0] pin_analog,
  // port pins
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe_n,
  // change notification
  input wire logic [23:0] change_pin,
  output logic [23:0] change_pullup_en,
  input wire logic change_flag_clr,
  output logic change_flag,
  output logic change_wake
);

  sgpio_pkg::sgpio_port_st_t st_q;
  sgpio_pkg::sgpio_port_st_t st_d;
  logic [15:0] analog_now;
  logic [15:0] periph_owns;
  logic [15:0] port_owns;
  logic [15:0] port_drives;
  logic [15:0] pad_driven;

  sgpio_cn_if cn_bus ();

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  // a converter's cleared bit only counts while that converter is enabled
  function automatic logic [15:0] analog_sel(
    input logic [15:0] cfg1,
    input logic [15:0] cfg2,
    input logic dis1,
    input logic dis2
  );
    logic [15:0] a1;
    logic [15:0] a2;
    a1 = ~cfg1 & {16{~dis1}};
    a2 = ~cfg2 & {16{~dis2}};
    analog_sel = (a1 | a2) & sgpio_pkg::ANALOG_MASK & sgpio_pkg::IMPL_MASK;
  endfunction

  assign analog_now = analog_sel(st_q.analog_cfg_1, st_q.analog_cfg_2,
    adc1_disable, adc2_disable);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    if (wr_direction) begin
      st_d.pin_direction_reg = wdata & sgpio_pkg::IMPL_MASK;
    end
    // both the latch and the port address land in the latch
    if (wr_latch || wr_pin_value) begin
      st_d.output_latch_reg = wdata & sgpio_pkg::IMPL_MASK;
    end
    if (wr_open_drain) begin
      st_d.open_drain_select_reg = wdata & sgpio_pkg::IMPL_MASK;
    end
    // pins without analog function stay digital
    if (wr_analog_cfg_1) begin
      st_d.analog_cfg_1 = wdata | ~sgpio_pkg::ANALOG_MASK;
    end
    if (wr_analog_cfg_2) begin
      st_d.analog_cfg_2 = wdata | ~sgpio_pkg::ANALOG_MASK;
    end
    if (wr_change_en_a) begin
      st_d.change_irq_enable[sgpio_pkg::CN_A_W-1:0] = wdata;
    end
    if (wr_change_en_b) begin
      st_d.change_irq_enable[sgpio_pkg::CN_W-1:sgpio_pkg::CN_B_LSB] =
        wdata[sgpio_pkg::CN_B_W-1:0];
    end
    if (wr_pullup_a) begin
      st_d.weak_pullup_enable[sgpio_pkg::CN_A_W-1:0] = wdata;
    end
    if (wr_pullup_b) begin
      st_d.weak_pullup_enable[sgpio_pkg::CN_W-1:sgpio_pkg::CN_B_LSB] =
        wdata[sgpio_pkg::CN_B_W-1:0];
    end
    // two-stage sync plus the value register; readback lags the pin by three cycles
    st_d.pin_s1 = pin_in;
    st_d.pin_s2 = st_q.pin_s1;
    st_d.pin_value_reg = st_q.pin_s2 & ~analog_now & sgpio_pkg::IMPL_MASK;
    if (rst) begin
      st_d.pin_direction_reg = sgpio_pkg::DIR_RST & sgpio_pkg::IMPL_MASK;
      st_d.output_latch_reg = sgpio_pkg::LAT_RST;
      st_d.open_drain_select_reg = sgpio_pkg::ODC_RST;
      st_d.analog_cfg_1 = sgpio_pkg::ANALOG_SELECT_BIT_RST | ~sgpio_pkg::ANALOG_MASK;
      st_d.analog_cfg_2 = sgpio_pkg::ANALOG_SELECT_BIT_RST | ~sgpio_pkg::ANALOG_MASK;
      st_d.change_irq_enable = sgpio_pkg::CN_EN_RST;
      st_d.weak_pullup_enable = sgpio_pkg::CN_PU_RST;
      st_d.pin_s1 = '0;
      st_d.pin_s2 = '0;
      st_d.pin_value_reg = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  // ----------------------------------------
  // pin arbitration
  // ----------------------------------------
  // input-only sharers have no driver to compete with
  assign periph_owns = periph_enable & periph_drive & ~sgpio_pkg::INPUT_ONLY_MASK
    & sgpio_pkg::IMPL_MASK;
  assign port_owns = ~periph_owns & sgpio_pkg::IMPL_MASK;
  assign port_drives = port_owns & ~st_q.pin_direction_reg;
  // open-drain releases the pad for a high latch bit
  assign pad_driven = periph_owns
    | (port_drives & ~(st_q.open_drain_select_reg & st_q.output_latch_reg));
  assign pin_oe_n = ~pad_driven;
  assign pin_out = (periph_owns & periph_out)
    | (port_drives & st_q.output_latch_reg & ~st_q.open_drain_select_reg);
  // peripheral sees nothing on pins the port is driving
  assign periph_in = st_q.pin_s2 & ~port_drives & sgpio_pkg::IMPL_MASK;
  assign pin_analog = analog_now;

  // ----------------------------------------
  // readback
  // ----------------------------------------
  assign pin_direction_reg = st_q.pin_direction_reg;
  assign output_latch_reg = st_q.output_latch_reg;
  assign pin_value_reg = st_q.pin_value_reg;
  assign open_drain_select_reg = st_q.open_drain_select_reg;
  assign analog_cfg_1 = st_q.analog_cfg_1;
  assign analog_cfg_2 = st_q.analog_cfg_2;
  assign change_irq_enable_reg_a = st_q.change_irq_enable[sgpio_pkg::CN_A_W-1:0];
  assign change_irq_enable_reg_b =
    st_q.change_irq_enable[sgpio_pkg::CN_W-1:sgpio_pkg::CN_B_LSB];
  assign weak_pullup_enable_reg_a = st_q.weak_pullup_enable[sgpio_pkg::CN_A_W-1:0];
  assign weak_pullup_enable_reg_b =
    st_q.weak_pullup_enable[sgpio_pkg::CN_W-1:sgpio_pkg::CN_B_LSB];
  assign change_pullup_en = st_q.weak_pullup_enable;

  // ----------------------------------------
  // change notification
  // ----------------------------------------
  assign cn_bus.raw = change_pin;
  assign cn_bus.en = st_q.change_irq_enable;
  assign cn_bus.clr = change_flag_clr;
  assign change_flag = cn_bus.flag;
  assign change_wake = cn_bus.wake;

  sgpio_cn u_cn (
    .mclk(mclk),
    .rst(rst),
    .cn(cn_bus.cn)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_reset_all_inputs: assert property (disable iff (1'b0)
    rst |=> pin_direction_reg == (sgpio_pkg::DIR_RST & sgpio_pkg::IMPL_MASK))
    else $error("pins not inputs after reset");
  a_periph_takes_pin: assert property (
    ((periph_owns & (pin_oe_n | (pin_out ^ periph_out))) == 16'h0000))
    else $error("active peripheral lost its pin");
  a_idle_periph_port: assert property (
    ((periph_enable & ~periph_drive & ~pin_direction_reg & ~open_drain_select_reg
      & pin_oe_n & sgpio_pkg::IMPL_MASK) == 16'h0000))
    else $error("port blocked by idle peripheral");
  a_no_loop_through: assert property (
    ((periph_in & ~pin_oe_n & ~periph_owns) == 16'h0000))
    else $error("port output fed peripheral input");
  a_input_pin_floats: assert property (
    ((pin_direction_reg & ~periph_owns & ~pin_oe_n) == 16'h0000))
    else $error("input pin driven by port");
  a_port_write_latch: assert property (
    wr_pin_value && !wr_latch |=> output_latch_reg == ($past(wdata) & sgpio_pkg::IMPL_MASK))
    else $error("port write missed latch");
  a_missing_bits_zero: assert property (
    (((pin_direction_reg | output_latch_reg | pin_value_reg) & ~sgpio_pkg::IMPL_MASK)
      == 16'h0000))
    else $error("unimplemented bit reads nonzero");
  a_input_only_owned: assert property (
    ((sgpio_pkg::INPUT_ONLY_MASK & ~pin_direction_reg & sgpio_pkg::IMPL_MASK
      & pin_oe_n & ~open_drain_select_reg) == 16'h0000))
    else $error("input-only sharer took pin");
  a_open_drain_low: assert property (
    ((port_drives & open_drain_select_reg & ~pin_oe_n & pin_out) == 16'h0000))
    else $error("open-drain pin drove high");
  a_analog_reads_zero: assert property (
    ##1 ((pin_value_reg & $past(analog_now)) == 16'h0000))
    else $error("analog pin read nonzero");
  a_disabled_adc_digital: assert property (
    adc1_disable && adc2_disable |-> pin_analog == 16'h0000)
    else $error("disabled converter kept pin analog");
  a_pin_readback_delay: assert property (
    ##3 (pin_value_reg == ($past(pin_in, 3) & ~$past(analog_now)
      & sgpio_pkg::IMPL_MASK)))
    else $error("pin readback wrong after sync");

  // ----------------------------------------
  // write and reset checks
  // ----------------------------------------
  a_dir_write_stores: assert property (
    wr_direction |=> pin_direction_reg == ($past(wdata) & sgpio_pkg::IMPL_MASK))
    else $error("direction write lost");
  a_odc_write_stores: assert property (
    wr_open_drain |=> open_drain_select_reg == ($past(wdata) & sgpio_pkg::IMPL_MASK))
    else $error("open-drain write lost");
  a_cfg_write_stores: assert property (
    wr_analog_cfg_1 |=> analog_cfg_1 == ($past(wdata) | ~sgpio_pkg::ANALOG_MASK))
    else $error("converter config write lost");
  // must run while reset is high, so the default disable is overridden
  a_reset_analog_pins: assert property (disable iff (1'b0)
    rst |=> analog_cfg_1 == (sgpio_pkg::ANALOG_SELECT_BIT_RST | ~sgpio_pkg::ANALOG_MASK)
      && analog_cfg_2 == (sgpio_pkg::ANALOG_SELECT_BIT_RST | ~sgpio_pkg::ANALOG_MASK))
    else $error("analog pins not analog after reset");
  a_either_adc_analog: assert property (
    !adc1_disable && !adc2_disable
      |-> pin_analog == ((~analog_cfg_1 | ~analog_cfg_2) & sgpio_pkg::ANALOG_MASK))
    else $error("analog select not an or of converters");
  a_change_en_b: assert property (
    wr_change_en_b |=> change_irq_enable_reg_b == $past(wdata[sgpio_pkg::CN_B_W-1:0]))
    else $error("change enable write lost");
  a_pullup_write: assert property (
    wr_pullup_a |=> weak_pullup_enable_reg_a == $past(wdata))
    else $error("pull-up enable write lost");
  a_latch_drives_pin: assert property (
    ((port_drives & ~open_drain_select_reg & (pin_oe_n | (pin_out ^ output_latch_reg)))
      == 16'h0000))
    else $error("push-pull pin lost latch value");
  c_periph_drives: cover property (|periph_owns ##1 ~|periph_owns);
  c_open_drain_release: cover property (|(port_drives & open_drain_select_reg & pin_oe_n));
  c_change_flag: cover property (change_flag_clr ##1 change_flag);

endmodule
